// >>> sfr_pkg.sv
/*
 Package for the safety fault reporter: register map, codes, field positions, timing.
 Assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package sfr_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int SYNC_WINDOW_MS = 1000;
    localparam int SYNC_WINDOW_CYC = CLK_HZ / 1000 * SYNC_WINDOW_MS;
    localparam int STOP_DELAY_DEF = 1000;

    localparam logic [3:0] ADDR_ERROR_CODE = 4'h0;
    localparam logic [3:0] ADDR_ERROR_SUB = 4'h1;
    localparam logic [3:0] ADDR_WARNING = 4'h2;
    localparam logic [3:0] ADDR_CONTROL = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
    localparam logic [3:0] ADDR_STOP_DELAY = 4'h6;
    localparam logic [3:0] ADDR_STATE = 4'h7;

    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_SAFE_STATE = 16'h0190;
    localparam logic [15:0] ERR_CHANNEL = 16'h0191;
    localparam logic [15:0] ERR_COMM = 16'h0192;

    localparam logic [7:0] SUB_CHANNEL = 8'h01;
    localparam logic [7:0] SUB_EXCEPTION = 8'h02;

    localparam int WARN_DELAYED_STOP_BIT = 12;
    localparam int WARN_SYNC_BIT = 13;

    localparam int CTRL_ACK_BIT = 0;
    localparam int CTRL_MODE_BIT = 1;

    localparam int IRQ_ERR_BIT = 0;
    localparam int IRQ_WARN_BIT = 1;
    localparam int IRQ_ACK_REFUSED_BIT = 2;
    localparam int IRQ_WIDTH = 3;

    localparam logic [31:0] STOP_DELAY_RESET = 32'h0000_0000;
    localparam logic [31:0] BAD_ADDR_DATA = 32'hdead_0000;

    typedef enum logic [2:0] {
        SFR_RUN,
        SFR_STOP_DELAY,
        SFR_SAFE,
        SFR_FAULT_SYNC,
        SFR_FAULT_HARD
    } sfr_state_t;
endpackage

// >>> sfr_sync_window.sv
/*
 Two-channel sync window monitor for one safety input pair.
 Assumes channel inputs already synchronous to clk; reset is the released copy.
*/
`timescale 1ns/100ps
module sfr_sync_window #(
    parameter int WINDOW_CYC = sfr_pkg::SYNC_WINDOW_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ch_a,
    input wire logic ch_b,
    input wire logic cross_short,
    output logic sync_fault,
    output logic cross_fault
);
    typedef struct packed {
        logic a_d;
        logic b_d;
        logic running;
        logic [31:0] cnt;
        logic sync_fault;
        logic cross_fault;
    } sfr_sw_t;

    sfr_sw_t s_reg;
    sfr_sw_t s_next;

    if (WINDOW_CYC < 1) begin
        $error("sync window must be at least one cycle");
    end

    always_comb begin
        s_next = s_reg;
        s_next.a_d = ch_a;
        s_next.b_d = ch_b;
        s_next.sync_fault = 1'b0;
        s_next.cross_fault = cross_short;
        if ((ch_a ^ s_reg.a_d) || (ch_b ^ s_reg.b_d)) begin
            // Mismatch starts the window, agreement cancels it
            if (ch_a != ch_b) begin
                s_next.running = 1'b1;
                s_next.cnt = '0;
            end else begin
                s_next.running = 1'b0;
            end
        end else if (s_reg.running) begin
            if (s_reg.cnt >= 32'(WINDOW_CYC - 1)) begin
                s_next.sync_fault = 1'b1;
                s_next.running = 1'b0;
            end else begin
                s_next.cnt = s_reg.cnt + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            // Closed-circuit idle level, so no false edge after reset
            s_reg.a_d <= 1'b1;
            s_reg.b_d <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_fault = s_reg.sync_fault;
    assign cross_fault = s_reg.cross_fault;
endmodule

// >>> sfr_top.sv
/*
 Safety fault reporter: error code, warning word, control word over Avalon-MM.
 Assumes synchronous safety inputs and fault flags from the safety module.
*/
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
// Notes on behaviour
// - Safety errors appear as numeric code in error code register.
// - Warnings appear in a separate warning word register.
// - Errors 400 and 401 subindex 1 stay latched until acknowledged via control word after cause removed.
// - Warning bits follow their condition and need no acknowledge.
// - Correct torque-off or delayed stop reaching safe state posts code 400.
// - Module-detected torque-off fault posts code 400 with safe state held.
// - Channel pair not agreeing within one second posts 401 subindex 1.
// - Cross-circuit between channels posts 401 subindex 1.
// - Internal exception posts 401 subindex two or more; only reset recovers.
// - Internal communication torque-off fault forces safe state, posts 402.
// - Delayed stop sets warning bit 12, safe state after stop delay.
// - Sync violation also sets warning bit 13.
// - After acknowledged channel error a new trigger is accepted.
// - Safe state drives safe-state output; module error drives module-error output.
`timescale 1ns/100ps
module sfr_top #(
    parameter int SYNC_WINDOW_CYC = sfr_pkg::SYNC_WINDOW_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic safety_in_a,
    input wire logic safety_in_b,
    input wire logic cross_short,
    input wire logic module_torque_fault,
    input wire logic comm_torque_fault,
    input wire logic exception_fault,
    input wire logic [7:0] exception_sub,
    output logic torque_off,
    output logic safe_state_output,
    output logic module_error_output,
    output logic irq
);
    typedef struct packed {
        logic [15:0] err_code;
        logic [7:0] err_sub;
        logic [15:0] warn;
        logic delayed_mode;
        logic [31:0] stop_delay;
        logic [31:0] delay_cnt;
        logic [sfr_pkg::IRQ_WIDTH-1:0] irq_status;
        logic [sfr_pkg::IRQ_WIDTH-1:0] irq_mask;
        sfr_pkg::sfr_state_t state;
        logic [31:0] rdata;
        logic ack_done;
        logic torque_off;
        logic safe_out;
        logic err_out;
        logic irq;
    } sfr_top_t;

    sfr_top_t s_reg;
    sfr_top_t s_next;
    logic rst_int_n;
    logic sync_fault;
    logic cross_fault;
    logic inputs_closed;
    logic ch_fault;
    logic wr_ack;
    logic [15:0] warn_now;
    logic [31:0] rd_mux;

    if (SYNC_WINDOW_CYC < 1) begin
        $error("SYNC_WINDOW_CYC must be positive");
    end

    // Reset release through two flops
    logic [1:0] rst_pipe;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_int_n = rst_pipe[1];

    sfr_sync_window #(
        .WINDOW_CYC(SYNC_WINDOW_CYC)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_int_n),
        .ch_a(safety_in_a),
        .ch_b(safety_in_b),
        .cross_short(cross_short),
        .sync_fault(sync_fault),
        .cross_fault(cross_fault)
    );

    assign inputs_closed = safety_in_a & safety_in_b;
    assign ch_fault = sync_fault | cross_fault;
    // Writes act at the answer edge, where waitrequest is seen low
    assign wr_ack = avs_write && s_reg.ack_done && (avs_address == sfr_pkg::ADDR_CONTROL)
        && avs_writedata[sfr_pkg::CTRL_ACK_BIT];

    always_comb begin
        warn_now = 16'h0000;
        warn_now[sfr_pkg::WARN_DELAYED_STOP_BIT] = (s_reg.state == sfr_pkg::SFR_STOP_DELAY);
        // Sync warning holds while the channel error is pending and the inputs are not both closed
        warn_now[sfr_pkg::WARN_SYNC_BIT] = (s_reg.state == sfr_pkg::SFR_FAULT_SYNC) && !inputs_closed;
    end

    always_comb begin
        case (avs_address)
            sfr_pkg::ADDR_ERROR_CODE: rd_mux = {16'h0000, s_reg.err_code};
            sfr_pkg::ADDR_ERROR_SUB: rd_mux = {24'h000000, s_reg.err_sub};
            sfr_pkg::ADDR_WARNING: rd_mux = {16'h0000, s_reg.warn};
            sfr_pkg::ADDR_CONTROL: rd_mux = {30'h00000000, s_reg.delayed_mode, 1'b0};
            sfr_pkg::ADDR_IRQ_STATUS: rd_mux = {29'h00000000, s_reg.irq_status};
            sfr_pkg::ADDR_IRQ_MASK: rd_mux = {29'h00000000, s_reg.irq_mask};
            sfr_pkg::ADDR_STOP_DELAY: rd_mux = s_reg.stop_delay;
            sfr_pkg::ADDR_STATE: rd_mux = {29'h00000000, s_reg.state};
            default: rd_mux = sfr_pkg::BAD_ADDR_DATA;
        endcase
    end

    always_comb begin
        logic [sfr_pkg::IRQ_WIDTH-1:0] ev;
        logic [sfr_pkg::IRQ_WIDTH-1:0] clr;
        ev = '0;
        clr = '0;
        s_next = s_reg;
        s_next.warn = warn_now;
        // One wait cycle per access; ack_done marks the answer cycle
        s_next.ack_done = (avs_read || avs_write) && !s_reg.ack_done;
        s_next.rdata = rd_mux;

        if (avs_write && s_reg.ack_done) begin
            case (avs_address)
                sfr_pkg::ADDR_CONTROL: s_next.delayed_mode = avs_writedata[sfr_pkg::CTRL_MODE_BIT];
                sfr_pkg::ADDR_IRQ_STATUS: clr = avs_writedata[sfr_pkg::IRQ_WIDTH-1:0];
                sfr_pkg::ADDR_IRQ_MASK: s_next.irq_mask = avs_writedata[sfr_pkg::IRQ_WIDTH-1:0];
                sfr_pkg::ADDR_STOP_DELAY: s_next.stop_delay = avs_writedata;
                default: ;
            endcase
        end

        if (exception_fault) begin
            s_next.state = sfr_pkg::SFR_FAULT_HARD;
            s_next.err_code = sfr_pkg::ERR_CHANNEL;
            s_next.err_sub = (exception_sub < sfr_pkg::SUB_EXCEPTION) ? sfr_pkg::SUB_EXCEPTION : exception_sub;
            if (s_reg.state != sfr_pkg::SFR_FAULT_HARD) ev[sfr_pkg::IRQ_ERR_BIT] = 1'b1;
        end else if (comm_torque_fault && s_reg.state != sfr_pkg::SFR_FAULT_HARD) begin
            s_next.state = sfr_pkg::SFR_FAULT_HARD;
            s_next.err_code = sfr_pkg::ERR_COMM;
            s_next.err_sub = 8'h00;
            ev[sfr_pkg::IRQ_ERR_BIT] = 1'b1;
        end else begin
            case (s_reg.state)
                sfr_pkg::SFR_RUN: begin
                    if (ch_fault) begin
                        s_next.state = sfr_pkg::SFR_FAULT_SYNC;
                        s_next.err_code = sfr_pkg::ERR_CHANNEL;
                        s_next.err_sub = sfr_pkg::SUB_CHANNEL;
                        ev[sfr_pkg::IRQ_ERR_BIT] = 1'b1;
                        ev[sfr_pkg::IRQ_WARN_BIT] = sync_fault;
                    end else if (module_torque_fault) begin
                        s_next.state = sfr_pkg::SFR_SAFE;
                        s_next.err_code = sfr_pkg::ERR_SAFE_STATE;
                        s_next.err_sub = 8'h00;
                        ev[sfr_pkg::IRQ_ERR_BIT] = 1'b1;
                    end else if (!safety_in_a && !safety_in_b) begin
                        if (s_reg.delayed_mode) begin
                            s_next.state = sfr_pkg::SFR_STOP_DELAY;
                            s_next.delay_cnt = '0;
                            ev[sfr_pkg::IRQ_WARN_BIT] = 1'b1;
                        end else begin
                            s_next.state = sfr_pkg::SFR_SAFE;
                            s_next.err_code = sfr_pkg::ERR_SAFE_STATE;
                            s_next.err_sub = 8'h00;
                            ev[sfr_pkg::IRQ_ERR_BIT] = 1'b1;
                        end
                    end
                end
                sfr_pkg::SFR_STOP_DELAY: begin
                    if (s_reg.delay_cnt >= s_reg.stop_delay) begin
                        s_next.state = sfr_pkg::SFR_SAFE;
                        s_next.err_code = sfr_pkg::ERR_SAFE_STATE;
                        s_next.err_sub = 8'h00;
                        ev[sfr_pkg::IRQ_ERR_BIT] = 1'b1;
                    end else begin
                        s_next.delay_cnt = s_reg.delay_cnt + 32'h0000_0001;
                    end
                end
                sfr_pkg::SFR_SAFE, sfr_pkg::SFR_FAULT_SYNC: begin
                    if (wr_ack) begin
                        if (inputs_closed && !ch_fault && !module_torque_fault) begin
                            s_next.state = sfr_pkg::SFR_RUN;
                            s_next.err_code = sfr_pkg::ERR_NONE;
                            s_next.err_sub = 8'h00;
                        end else begin
                            ev[sfr_pkg::IRQ_ACK_REFUSED_BIT] = 1'b1;
                        end
                    end
                end
                sfr_pkg::SFR_FAULT_HARD: begin
                    if (wr_ack) ev[sfr_pkg::IRQ_ACK_REFUSED_BIT] = 1'b1;
                end
                default: s_next.state = sfr_pkg::SFR_SAFE;
            endcase
        end

        // Set beats clear
        s_next.irq_status = (s_reg.irq_status & ~clr) | ev;
        s_next.irq = |(s_next.irq_status & s_next.irq_mask);
        s_next.torque_off = (s_next.state != sfr_pkg::SFR_RUN) && (s_next.state != sfr_pkg::SFR_STOP_DELAY);
        s_next.safe_out = s_next.torque_off;
        s_next.err_out = (s_next.state == sfr_pkg::SFR_FAULT_SYNC) || (s_next.state == sfr_pkg::SFR_FAULT_HARD)
            || (s_next.state == sfr_pkg::SFR_SAFE && module_torque_fault);
    end

    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            s_reg <= '0;
            s_reg.state <= sfr_pkg::SFR_RUN;
            s_reg.stop_delay <= sfr_pkg::STOP_DELAY_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !s_reg.ack_done && avs_waitrequest);
        end
    end

    assign avs_readdata = s_reg.rdata;
    assign torque_off = s_reg.torque_off;
    assign safe_state_output = s_reg.safe_out;
    assign module_error_output = s_reg.err_out;
    assign irq = s_reg.irq;
endmodule

// >>> sfr_assertions.sv
/*
 Checker for the safety fault reporter top ports.
 Assumes one clock; bound from the bench with the sim sync window.
*/
`timescale 1ns/100ps
module sfr_assertions #(
    parameter int SYNC_WINDOW_CYC = 50
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic safety_in_a,
    input wire logic safety_in_b,
    input wire logic cross_short,
    input wire logic module_torque_fault,
    input wire logic comm_torque_fault,
    input wire logic exception_fault,
    input wire logic torque_off,
    input wire logic safe_state_output,
    input wire logic module_error_output
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    int skew_cnt;
    logic ans_rd;
    assign ans_rd = avs_read && !avs_waitrequest;
    // Cycles the channels disagree while running
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) skew_cnt <= 0;
        else if (torque_off || safety_in_a == safety_in_b) skew_cnt <= 0;
        else if (skew_cnt < SYNC_WINDOW_CYC + 8) skew_cnt <= skew_cnt + 1;
    end
    property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("bus request not answered");
    property p_code; ans_rd && avs_address == sfr_pkg::ADDR_ERROR_CODE |->
        avs_readdata inside {32'h0, 32'h190, 32'h191, 32'h192}; endproperty
    a_code: assert property (p_code) else $error("error code outside the code set");
    property p_unmapped; ans_rd && avs_address[3] |-> avs_readdata == sfr_pkg::BAD_ADDR_DATA; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read data wrong");
    property p_warn; ans_rd && avs_address == sfr_pkg::ADDR_WARNING |-> (avs_readdata & ~32'h3000) == 0; endproperty
    a_warn: assert property (p_warn) else $error("warning word has stray bits");
    property p_trip; !safety_in_a && !safety_in_b |-> ##[1:40] torque_off; endproperty
    a_trip: assert property (p_trip) else $error("trip did not reach safe state");
    property p_module; module_torque_fault |-> ##[1:4] (torque_off && module_error_output); endproperty
    a_module: assert property (p_module) else $error("module fault not reported");
    property p_comm; comm_torque_fault |-> ##[1:4] (torque_off && module_error_output); endproperty
    a_comm: assert property (p_comm) else $error("comm fault not reported");
    property p_exc; exception_fault |-> ##[1:4] module_error_output; endproperty
    a_exc: assert property (p_exc) else $error("exception not reported");
    property p_cross; cross_short && !torque_off |-> ##[1:4] module_error_output; endproperty
    a_cross: assert property (p_cross) else $error("cross short not reported");
    property p_sync; skew_cnt > SYNC_WINDOW_CYC + 4 |-> module_error_output; endproperty
    a_sync: assert property (p_sync) else $error("sync window overrun not reported");
    property p_safe_out; safe_state_output == torque_off; endproperty
    a_safe_out: assert property (p_safe_out) else $error("safe state output differs");
    property p_leave; $fell(torque_off) |->
        safety_in_a && safety_in_b && ($past(avs_write) || $past(avs_write, 2)); endproperty
    a_leave: assert property (p_leave) else $error("safe state left without ack");
endmodule

// >>> sfr_fieldbus_ctrl.sv
/*
 Fieldbus controller model: one Avalon-MM master transfer per go pulse.
 Assumes go is raised for one cycle only while no transfer is open.
*/
`timescale 1ns/100ps
module sfr_fieldbus_ctrl (
    input wire logic clk,
    input wire logic go,
    input wire logic go_wr,
    input wire logic [3:0] go_addr,
    input wire logic [31:0] go_data,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [3:0] avs_address = 4'h0,
    output logic avs_read = 1'b0,
    output logic avs_write = 1'b0,
    output logic [31:0] avs_writedata = 32'h0,
    output logic [31:0] rdata = 32'h0,
    output logic done = 1'b0
);
    always @(posedge clk) begin
        done <= 1'b0;
        if (go && !avs_read && !avs_write) begin
            avs_read <= !go_wr;
            avs_write <= go_wr;
            avs_address <= go_addr;
            avs_writedata <= go_data;
        end else if ((avs_read || avs_write) && !avs_waitrequest) begin
            rdata <= avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            avs_writedata <= ~avs_writedata; // Stale data must not look valid
            done <= 1'b1;
        end
    end
endmodule

// >>> sfr_top_bench.sv
/*
 Bench for the safety fault reporter with a fieldbus controller model.
 Assumes a shortened sync window and stop delays of 20 to 29 cycles.
*/
`timescale 1ns/100ps
module sfr_top_bench;
    localparam int SYNC_WINDOW_CYC = 50;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic go = 1'b0;
    logic go_wr = 1'b0;
    logic [3:0] go_addr = 4'h0;
    logic [31:0] go_data = 32'h0;
    logic safety_in_a = 1'b1;
    logic safety_in_b = 1'b1;
    logic cross_short = 1'b0;
    logic module_torque_fault = 1'b0;
    logic comm_torque_fault = 1'b0;
    logic exception_fault = 1'b0;
    logic [7:0] exception_sub = 8'h00;
    logic [3:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest, torque_off, safe_state_output, module_error_output, irq, done;
    logic [31:0] avs_writedata, avs_readdata, rdata;
    int bad_count = 0, checks = 0, cyc = 0, m_err = 0, m_sub = 0, m_warn = 0, d, t0, s;
    integer seed = 32'h8e0385ff;
    always #4 clk = ~clk;
    sfr_top #(.SYNC_WINDOW_CYC(SYNC_WINDOW_CYC)) u_sfr_top (.clk(clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .safety_in_a(safety_in_a),
        .safety_in_b(safety_in_b), .cross_short(cross_short), .module_torque_fault(module_torque_fault),
        .comm_torque_fault(comm_torque_fault), .exception_fault(exception_fault), .exception_sub(exception_sub),
        .torque_off(torque_off), .safe_state_output(safe_state_output),
        .module_error_output(module_error_output), .irq(irq));
    sfr_fieldbus_ctrl u_sfr_fieldbus_ctrl (.clk(clk), .go(go), .go_wr(go_wr), .go_addr(go_addr),
        .go_data(go_data), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .rdata(rdata), .done(done));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
        @(posedge clk);
        go <= 1'b1;
        go_wr <= wr;
        go_addr <= ad;
        go_data <= wd;
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 20; i++) begin
            @(negedge clk);
            if (done) break;
        end
        chk({31'h0, done}, 32'h1);
    endtask
    task automatic ack;
        xfer(1'b1, sfr_pkg::ADDR_CONTROL, 32'h1);
    endtask
    task automatic check_regs;
        xfer(1'b0, sfr_pkg::ADDR_ERROR_CODE, 32'h0);
        chk(rdata, 32'(m_err));
        xfer(1'b0, sfr_pkg::ADDR_WARNING, 32'h0);
        chk(rdata, 32'(m_warn));
        if (m_err == 401) begin
            xfer(1'b0, sfr_pkg::ADDR_ERROR_SUB, 32'h0);
            chk(rdata, 32'(m_sub));
        end
    endtask
    task automatic outs(input logic [3:0] exp);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({28'h0, torque_off, safe_state_output, module_error_output, irq}, {28'h0, exp});
    endtask
    task automatic set_in(input logic a, input logic b);
        @(posedge clk);
        safety_in_a <= a;
        safety_in_b <= b;
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic restart;
        repeat (10) @(posedge clk);
        set_in(1'b1, 1'b1);
        ack();
        m_err = 0;
        check_regs();
    endtask
    initial begin
        do_reset();
        for (int i = 0; i < 8; i++) begin
            xfer(1'b0, 4'(i), 32'h0);
            chk(rdata, 32'h0);
        end
        xfer(1'b0, 4'hc, 32'h0);
        chk(rdata, sfr_pkg::BAD_ADDR_DATA);
        $display("test reset values done");
        xfer(1'b1, sfr_pkg::ADDR_IRQ_MASK, 32'h7);
        set_in(1'b0, 1'b1);
        d = 10 + ($unsigned($random(seed)) % 30);
        repeat (d) @(posedge clk);
        set_in(1'b0, 1'b0);
        m_err = 400;
        check_regs();
        outs(4'b1101);
        ack();
        check_regs();
        xfer(1'b0, sfr_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk(rdata, 32'h5);
        xfer(1'b1, sfr_pkg::ADDR_IRQ_STATUS, 32'h7);
        outs(4'b1100);
        restart();
        outs(4'b0000);
        $display("test direct trip done");
        d = 20 + ($unsigned($random(seed)) % 10);
        xfer(1'b1, sfr_pkg::ADDR_STOP_DELAY, 32'(d));
        xfer(1'b1, sfr_pkg::ADDR_CONTROL, 32'h2);
        set_in(1'b0, 1'b0);
        t0 = cyc;
        xfer(1'b0, sfr_pkg::ADDR_WARNING, 32'h0);
        chk(rdata, 32'h1000);
        while (torque_off !== 1'b1 && cyc - t0 < 100) @(negedge clk);
        chk(32'(cyc - t0 >= d + 1 && cyc - t0 <= d + 4), 32'h1);
        m_err = 400;
        check_regs();
        restart();
        $display("test delayed stop done");
        set_in(1'b1, 1'b0);
        repeat (SYNC_WINDOW_CYC + 10) @(posedge clk);
        m_err = 401;
        m_sub = 1;
        m_warn = 32'h2000;
        check_regs();
        outs(4'b1111);
        set_in(1'b1, 1'b1);
        m_warn = 0;
        check_regs();
        ack();
        m_err = 0;
        check_regs();
        set_in(1'b0, 1'b0);
        m_err = 400;
        check_regs();
        restart();
        $display("test sync window done");
        @(posedge clk);
        cross_short <= 1'b1;
        repeat (2) @(posedge clk);
        cross_short <= 1'b0;
        m_err = 401;
        check_regs();
        ack();
        m_err = 0;
        check_regs();
        @(posedge clk);
        module_torque_fault <= 1'b1;
        m_err = 400;
        check_regs();
        outs(4'b1111);
        @(posedge clk);
        module_torque_fault <= 1'b0;
        xfer(1'b1, sfr_pkg::ADDR_IRQ_MASK, 32'h0);
        restart();
        outs(4'b0000);
        $display("test faults and mask done");
        @(posedge clk);
        comm_torque_fault <= 1'b1;
        repeat (2) @(posedge clk);
        comm_torque_fault <= 1'b0;
        m_err = 402;
        check_regs();
        ack();
        check_regs();
        do_reset();
        for (int k = 0; k < 3; k++) begin
            s = (k == 2) ? ($unsigned($random(seed)) % 256) : k;
            @(posedge clk);
            exception_sub <= 8'(s);
            exception_fault <= 1'b1;
            repeat (2) @(posedge clk);
            exception_fault <= 1'b0;
            m_err = 401;
            m_sub = (s < 2) ? 2 : s;
            check_regs();
            do_reset();
            m_err = 0;
            check_regs();
        end
        $display("test hard faults done");
        end_of_test();
    end
endmodule
bind sfr_top sfr_assertions #(.SYNC_WINDOW_CYC(SYNC_WINDOW_CYC)) u_sfr_assertions (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .safety_in_a(safety_in_a), .safety_in_b(safety_in_b),
    .cross_short(cross_short), .module_torque_fault(module_torque_fault), .comm_torque_fault(comm_torque_fault),
    .exception_fault(exception_fault), .torque_off(torque_off), .safe_state_output(safe_state_output),
    .module_error_output(module_error_output));
